/* File: verification/tb.sv */
// self-checking testbench of the timed i/o port unit
`timescale 1ns/1ps
module tb;
  import tio_pkg::*;
  logic             clk_i   = 1'b0;
  logic             rst_n_i = 1'b0;
  logic [AW-1:0]    addr_i  = 8'h00;
  logic [DW-1:0]    wdata_i = 32'h0;
  logic             wr_i    = 1'b0;
  logic             rd_i    = 1'b0;
  logic [DW-1:0]    rdata_o;
  logic [PINS-1:0]  pin_i;
  logic [PINS-1:0]  pin_o;
  logic [PINS-1:0]  pin_oe_o;
  logic [NPORT-1:0] strobe_i;
  logic [NPORT-1:0] outgoing_strobe_o;
  logic [NPORT-1:0] event_o;
  logic             irq_o;
  logic [PINS-1:0]  ext_val = 32'h0;
  logic             ext_en  = 1'b0;
  logic [NPORT-1:0] ext_stb = 5'h00;
  logic [DW-1:0]    rv;
  int               ev0 = 0;
  int               miscompares = 0;
  int               check_count = 0;

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) ev0 <= ev0 + int'(event_o[0]);

  tio_port_unit dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .strobe_i(strobe_i), .outgoing_strobe_o(outgoing_strobe_o),
    .event_o(event_o), .irq_o(irq_o)
  );
  tio_pin_model model (
    .dev_pin_i(pin_o), .dev_oe_i(pin_oe_o), .ext_val_i(ext_val), .ext_en_i(ext_en),
    .ext_stb_i(ext_stb), .pin_o(pin_i), .strobe_o(strobe_i)
  );

  // =====================================================================
  // helpers
  function automatic logic [AW-1:0] pa(input int p, input logic [2:0] r);
    return 8'h40 + 8'(p * 32) + {3'h0, r, 2'h0};
  endfunction
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic give_up;
    miscompares++;
    test_done();
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(posedge clk_i);
    d = rdata_o;
  endtask
  task automatic wait_ev(input int e0, input int lim);
    int k;
    k = 0;
    while (ev0 == e0) begin
      if (k == lim) give_up();
      @(posedge clk_i);
      k++;
    end
  endtask

  // =====================================================================
  // scenarios
  task automatic test_reset;
    check(pin_oe_o, 32'h0);
    for (int p = 0; p < NPORT; p++) begin
      rd(pa(p, PR_CFG), rv);
      check(rv, 32'h0);
    end
    rd(OFS_CLK_BASE, rv);
    check(rv, 32'h0);
    wr(8'hfc, 32'hffff_ffff);
    rd(8'hfc, rv);
    check(rv, 32'h0);
  endtask
  task automatic test_serial_out;
    logic [DW-1:0] w;
    int            k;
    int            e0;
    w  = 32'h9c3a_5e61;
    e0 = ev0;
    wr(OFS_MASK, 32'h0);
    wr(pa(0, PR_CFG), 32'h103);
    wr(pa(0, PR_DATA), w);
    k = 0;
    while (pin_o[0] !== 1'b1) begin
      if (k == 8) give_up();
      @(posedge clk_i);
      k++;
    end
    for (int i = 1; i < 32; i++) begin
      @(posedge clk_i);
      check(32'(pin_o[0]), 32'(w[i]));
      if (i == 16) check(32'(outgoing_strobe_o[0]), 32'h1);
    end
    wait_ev(e0, 40);
    cycles(4);
    check(32'(ev0 - e0), 32'h1);
    rd(OFS_STATUS, rv);
    check(rv & 32'h1f, 32'h1);
    check(32'(irq_o), 32'h0);
    wr(OFS_MASK, 32'h1);
    cycles(2);
    check(32'(irq_o), 32'h1);
    wr(OFS_STATUS, 32'h1);
    cycles(2);
    check(32'(irq_o), 32'h0);
    rd(OFS_STATUS, rv);
    check(rv & 32'h1f, 32'h0);
  endtask
  task automatic test_counter;
    logic [DW-1:0] c0;
    logic [DW-1:0] c1;
    logic [DW-1:0] t;
    int            e0;
    rd(pa(0, PR_COUNT), c0);
    rd(pa(0, PR_COUNT), c1);
    check(c1, (c0 + 32'h2) & 32'hffff);
    cycles(int'(17'h1_0000 - 17'(c1[15:0])));
    rd(pa(0, PR_COUNT), c0);
    check(c0, 32'h2);
    wr(OFS_CLK_BASE + 8'h04, 32'h1);
    wr(pa(0, PR_CFG), 32'h107);
    rd(pa(0, PR_COUNT), c0);
    rd(pa(0, PR_COUNT), c1);
    check((c1 - c0) & 32'hffff, 32'h1);
    wr(pa(0, PR_CFG), 32'h43);
    rd(pa(0, PR_COUNT), c0);
    t  = (c0 + 32'd60) & 32'hffff;
    e0 = ev0;
    wr(pa(0, PR_TIME), t);
    wr(pa(0, PR_DATA), 32'h1234_5678);
    wait_ev(e0, 200);
    rd(pa(0, PR_TSTAMP), rv);
    check(rv, t);
    wr(pa(0, PR_CFG), 32'h4);
  endtask
  task automatic test_input;
    logic [DW-1:0] c0;
    int            k;
    ext_val <= 32'h5a5a;
    ext_en  <= 1'b1;
    wr(OFS_CLK_BASE + 8'h04, 32'h100);
    rd(pa(0, PR_COUNT), c0);
    wr(pa(3, PR_COND), 32'h5a5a);
    wr(pa(3, PR_CFG), 32'ha1);
    wr(pa(3, PR_CFG), 32'ha3);
    cycles(30);
    rd(pa(3, PR_CFG), rv);
    check(rv, 32'ha1);
    check(pin_oe_o, 32'h0);
    ext_val <= 32'h1111;
    ext_stb <= 5'h08;
    cycles(30);
    rd(pa(3, PR_CFG), rv);
    check(rv, 32'ha1);
    ext_val <= 32'h5a5a;
    k = 0;
    while (rv[31] !== 1'b1) begin
      if (k == 20) give_up();
      rd(pa(3, PR_CFG), rv);
      k++;
    end
    ext_stb <= 5'h00;
    cycles(3);
    rd(pa(3, PR_DATA), rv);
    check(rv, 32'h5a5a_5a5a);
    rd(pa(3, PR_CFG), rv);
    check(rv, 32'ha1);
    rd(pa(0, PR_COUNT), rv);
    check(32'(16'(rv - c0)), 32'h1);
    wr(pa(3, PR_CFG), 32'h0);
    ext_en  <= 1'b0;
  endtask
  task automatic test_sharing;
    wr(pa(1, PR_CFG), 32'h3);
    wr(pa(1, PR_DATA), 32'h0);
    wr(pa(4, PR_CFG), 32'h3);
    wr(pa(4, PR_DATA), 32'hffff_ffff);
    cycles(20);
    check(pin_oe_o, 32'hffff_ffff);
    check(pin_o, 32'hffff_fff0);
    wr(OFS_CTRL, 32'h1);
    cycles(3);
    check(pin_oe_o, 32'hffff_fff0);
    wr(OFS_CTRL, 32'h0);
    wr(pa(1, PR_CFG), 32'h0);
    wr(pa(4, PR_CFG), 32'h0);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    test_reset();
    test_serial_out();
    test_counter();
    test_input();
    test_sharing();
    test_done();
  end
endmodule

/* File: verification/tio_pin_model.sv */
// model of the external hardware on the general-purpose pins
`timescale 1ns/1ps
module tio_pin_model (
  input  wire logic [tio_pkg::PINS-1:0]  dev_pin_i,
  input  wire logic [tio_pkg::PINS-1:0]  dev_oe_i,
  input  wire logic [tio_pkg::PINS-1:0]  ext_val_i,
  input  wire logic                      ext_en_i,
  input  wire logic [tio_pkg::NPORT-1:0] ext_stb_i,
  output logic      [tio_pkg::PINS-1:0]  pin_o,
  output logic      [tio_pkg::NPORT-1:0] strobe_o
);
  import tio_pkg::*;

  // =====================================================================
  // wire level: device drive wins, released pins take ext_val_i while ext_en_i is set, else pulled down
  assign pin_o = (dev_oe_i & dev_pin_i) | (~dev_oe_i & ext_val_i & {PINS{ext_en_i}});
  // incoming strobe only while the hardware takes part
  assign strobe_o = ext_en_i ? ext_stb_i : 5'h00;
endmodule

/* File: verification/tio_port_unit_checker.sv */
// port checks of the timed i/o port unit
`timescale 1ns/1ps
module tio_port_unit_checker (
  input wire logic                      clk_i,
  input wire logic                      rst_n_i,
  input wire logic [tio_pkg::AW-1:0]    addr_i,
  input wire logic [tio_pkg::DW-1:0]    wdata_i,
  input wire logic                      wr_i,
  input wire logic                      rd_i,
  input wire logic [tio_pkg::DW-1:0]    rdata_o,
  input wire logic [tio_pkg::PINS-1:0]  pin_i,
  input wire logic [tio_pkg::PINS-1:0]  pin_o,
  input wire logic [tio_pkg::PINS-1:0]  pin_oe_o,
  input wire logic [tio_pkg::NPORT-1:0] strobe_i,
  input wire logic [tio_pkg::NPORT-1:0] outgoing_strobe_o,
  input wire logic [tio_pkg::NPORT-1:0] event_o,
  input wire logic                      irq_o
);
  import tio_pkg::*;
  logic             link_q;
  logic [NPORT-1:0] mask_q;
  logic [NPORT-1:0] mask_d1;

  // =====================================================================
  // shadow of link enable and mask
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_q <= 1'b0;
    end else if (wr_i && addr_i == OFS_CTRL) begin
      link_q <= wdata_i[CTRL_LINK];
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q  <= '0;
      mask_d1 <= '0;
    end else begin
      mask_d1 <= mask_q;
      if (wr_i && addr_i == OFS_MASK) begin
        mask_q <= wdata_i[NPORT-1:0];
      end
    end
  end

  // =====================================================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_bus_quiet;
    !rd_i;
  endsequence
  sequence s_event_on;
    event_o[0] && mask_q[0];
  endsequence
  property p_rd_zero;
    s_bus_quiet |=> rdata_o == 32'h0;
  endproperty
  property p_reset_quiet;
    $rose(rst_n_i) |-> pin_oe_o == 32'h0 && event_o == 5'h0 && !irq_o;
  endproperty
  property p_event_pulse;
    event_o[0] |=> !event_o[0];
  endproperty
  property p_event_irq;
    s_event_on |-> ##[1:4] irq_o;
  endproperty
  property p_irq_masked;
    mask_q == 5'h0 && mask_d1 == 5'h0 |=> !irq_o;
  endproperty
  property p_irq_cause;
    $rose(irq_o) |-> ($past(event_o, 1) | $past(event_o, 2) | $past(event_o, 3)) != 5'h0
      || $past(wr_i, 1) || $past(wr_i, 2) || $past(wr_i, 3);
  endproperty
  property p_link_free;
    link_q && $past(link_q, 2) |-> pin_oe_o[LINK_PINS-1:0] == 4'h0;
  endproperty
  property p_strobe_pin;
    outgoing_strobe_o[0] && !link_q |-> ##[0:2] pin_oe_o[0];
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("read data outside answer cycle");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  a_event_pulse: assert property (p_event_pulse)
    else $error("event longer than one cycle");
  a_event_irq: assert property (p_event_irq)
    else $error("unmasked event without irq");
  a_irq_masked: assert property (p_irq_masked)
    else $error("irq while all masked");
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq rose without cause");
  a_link_free: assert property (p_link_free)
    else $error("port drives link pins");
  a_strobe_pin: assert property (p_strobe_pin)
    else $error("strobe without driven pin");
endmodule

bind tio_port_unit tio_port_unit_checker u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o), .strobe_i(strobe_i), .outgoing_strobe_o(outgoing_strobe_o),
  .event_o(event_o), .irq_o(irq_o)
);

/* File: verilog/tio_pkg.sv */
// constants, field layouts and carrier types of the timed i/o port unit
package tio_pkg;

  // =====================================================================
  // sizes
  localparam int NPORT     = 5;
  localparam int NCLK      = 6;
  localparam int PINS      = 32;
  localparam int LINK_PINS = 4;
  localparam int AW        = 8;
  localparam int DW        = 32;
  localparam int CW        = 16;
  localparam int DIVW      = 8;
  localparam int PORT_W [NPORT] = '{1, 4, 8, 16, 32};

  // =====================================================================
  // register offsets
  localparam logic [AW-1:0] OFS_CTRL      = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS    = 8'h04;
  localparam logic [AW-1:0] OFS_MASK      = 8'h08;
  localparam logic [AW-1:0] OFS_CLK_BASE  = 8'h10;
  localparam logic [2:0]    PORT_BASE_SEL = 3'h2;
  localparam logic [2:0]    PR_CFG        = 3'h0;
  localparam logic [2:0]    PR_DATA       = 3'h1;
  localparam logic [2:0]    PR_TIME       = 3'h2;
  localparam logic [2:0]    PR_COND       = 3'h3;
  localparam logic [2:0]    PR_COUNT      = 3'h4;
  localparam logic [2:0]    PR_TSTAMP     = 3'h5;

  // =====================================================================
  // field positions
  localparam int CTRL_LINK  = 0;
  localparam int CFG_EN     = 0;
  localparam int CFG_DIR    = 1;
  localparam int CFG_CSEL   = 2;
  localparam int CFG_COND   = 5;
  localparam int CFG_TIME   = 6;
  localparam int CFG_STBI   = 7;
  localparam int CFG_STBO   = 8;
  localparam int CLK_EXT    = 8;

  // =====================================================================
  // reset values
  localparam logic [DIVW-1:0] CLK_DIV_RST = 8'h00;
  localparam logic [2:0]      CSEL_RST    = 3'h0;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic          en;
    logic          dir_out;
    logic [2:0]    csel;
    logic          cond_en;
    logic          time_en;
    logic          stbi_en;
    logic          stbo_en;
    logic [CW-1:0] at_time;
    logic [DW-1:0] cond;
  } tio_port_cfg_t;

  typedef struct packed {
    logic [CW-1:0] count;
    logic [CW-1:0] tstamp;
    logic [DW-1:0] rx_data;
    logic          rx_valid;
    logic          tx_full;
  } tio_port_stat_t;

endpackage

/* File: verilog/tio_port_unit.sv */
// timed i/o port unit: ports, serializers, counters, clock blocks, pin sharing
`timescale 1ns/1ps
// What this block does
// RL1: ports one, four, eight, sixteen, thirty-two wide
// RL2: each port drives or samples, never both
// RL3: drive pins, sample pins, optional pin condition
// RL4: every port access completes in one cycle
// RL5: serializer plus transfer register buffer data
// RL6: each port owns a sixteen-bit counter
// RL7: counter readable; future count delays transfer
// RL8: transfer captures counter as timestamp
// RL9: enabled link takes its pins from ports
// RL10: narrower enabled port beats wider sharing pins
// RL11: unshared pins stay with the wider port
// RL12: port always works at its own width
// RL13: six clock blocks, block zero reference
// RL14: blocks one to five have own dividers
// RL15: clock block may use one-bit port
// RL16: strobe in accepted, strobe out generated
// RL17: reset attaches every port to block zero
// RL18: pin events go straight to tile
// RL19: counter ticks per clock block, wraps

module tio_port #(
  parameter int W = 1
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  tio_pkg::tio_port_cfg_t      cfg_i,
  input  wire logic                   tick_i,
  input  wire logic [W-1:0]           pins_i,
  input  wire logic                   strobe_i,
  input  wire logic                   wr_data_i,
  input  wire logic [tio_pkg::DW-1:0] wdata_i,
  input  wire logic                   rd_data_i,
  output tio_pkg::tio_port_stat_t     stat_o,
  output logic      [W-1:0]           drive_o,
  output logic                        strobe_o,
  output logic                        event_o
);
  import tio_pkg::*;

  localparam logic [5:0] SLICES = 6'(DW / W);

  logic [CW-1:0] cnt; // RL6
  logic [CW-1:0] tstamp;
  logic [DW-1:0] txbuf;
  logic          tx_full;
  logic [DW-1:0] shreg;
  logic [5:0]    left;
  logic [DW-1:0] rxbuf;
  logic          rx_valid;
  logic          cnt_hit;
  logic          cond_ok;
  logic          accept_in;
  logic          tx_load;
  logic          tx_done;
  logic          rx_start;
  logic          rx_step;
  logic          rx_done;
  logic [DW-1:0] shifted_in;

  // =====================================================================
  // transfer conditions
  assign cnt_hit    = !cfg_i.time_en || (cnt == cfg_i.at_time);                  // RL7
  assign cond_ok    = !cfg_i.cond_en || (pins_i == cfg_i.cond[W-1:0]);           // RL3
  assign accept_in  = tick_i && cfg_i.en && !cfg_i.dir_out
                      && (!cfg_i.stbi_en || strobe_i);                           // RL16
  assign tx_load    = tick_i && cfg_i.en && cfg_i.dir_out && tx_full
                      && (left == 6'h00) && cnt_hit;
  assign tx_done    = tick_i && cfg_i.en && cfg_i.dir_out
                      && (tx_load ? (SLICES == 6'h01) : (left == 6'h01));
  assign rx_start   = accept_in && (left == 6'h00) && cond_ok && cnt_hit;
  assign rx_step    = accept_in && (left != 6'h00);
  assign rx_done    = (rx_start && (SLICES == 6'h01)) || (rx_step && (left == 6'h01));
  assign shifted_in = (shreg >> W) | (DW'(pins_i) << (DW - W));                  // RL12

  // =====================================================================
  // port counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 16'h0000;
    end else if (tick_i) begin
      cnt <= cnt + 16'h0001;                                                     // RL19
    end
  end

  // =====================================================================
  // transfer register, output side
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txbuf   <= 32'h0000_0000;
      tx_full <= 1'b0;
    end else begin
      if (tx_load || !cfg_i.en) begin
        tx_full <= 1'b0;
      end
      if (wr_data_i && cfg_i.en && cfg_i.dir_out && (!tx_full || tx_load)) begin
        txbuf   <= wdata_i;                                                      // RL5
        tx_full <= 1'b1;
      end
    end
  end

  // =====================================================================
  // serializer for both directions
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg    <= 32'h0000_0000;
      left     <= 6'h00;
      drive_o  <= '0;
      strobe_o <= 1'b0;
    end else if (!cfg_i.en) begin
      left     <= 6'h00;
      strobe_o <= 1'b0;
    end else if (tx_load) begin
      drive_o  <= txbuf[W-1:0];                                                  // RL3
      shreg    <= txbuf >> W;                                                    // RL5
      left     <= SLICES - 6'h01;
      strobe_o <= cfg_i.stbo_en;                                                 // RL16
    end else if (tick_i && cfg_i.dir_out && (left != 6'h00)) begin
      drive_o  <= shreg[W-1:0];
      shreg    <= shreg >> W;
      left     <= left - 6'h01;
      strobe_o <= cfg_i.stbo_en;
    end else if (rx_start) begin
      shreg    <= shifted_in;                                                    // RL5
      left     <= SLICES - 6'h01;
    end else if (rx_step) begin
      shreg    <= shifted_in;
      left     <= left - 6'h01;
    end else if (tick_i) begin
      strobe_o <= 1'b0;
    end
  end

  // =====================================================================
  // receive transfer register, capture wins over read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxbuf    <= 32'h0000_0000;
      rx_valid <= 1'b0;
    end else if (rx_done) begin
      rxbuf    <= shifted_in;
      rx_valid <= 1'b1;
    end else if (rd_data_i) begin
      rx_valid <= 1'b0;
    end
  end

  // =====================================================================
  // timestamp and event
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tstamp  <= 16'h0000;
      event_o <= 1'b0;
    end else begin
      event_o <= tx_done || rx_done;                                             // RL18
      if (tx_load || rx_start) begin
        tstamp <= cnt;                                                           // RL8
      end
    end
  end

  assign stat_o = '{count: cnt, tstamp: tstamp, rx_data: rxbuf,
                    rx_valid: rx_valid, tx_full: tx_full};
endmodule

module tio_port_unit (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic [tio_pkg::AW-1:0] addr_i,
  input  wire logic [tio_pkg::DW-1:0] wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [tio_pkg::DW-1:0] rdata_o,
  input  wire logic [tio_pkg::PINS-1:0] pin_i,
  output logic      [tio_pkg::PINS-1:0] pin_o,
  output logic      [tio_pkg::PINS-1:0] pin_oe_o,
  input  wire logic [tio_pkg::NPORT-1:0] strobe_i,
  output logic      [tio_pkg::NPORT-1:0] outgoing_strobe_o,
  output logic      [tio_pkg::NPORT-1:0] event_o,
  output logic                        irq_o
);
  import tio_pkg::*;

  logic [PINS-1:0]  pin_s1;
  logic [PINS-1:0]  pin_s2;
  logic             pin0_d;
  logic [NPORT-1:0] stb_s1;
  logic [NPORT-1:0] stb_s2;
  logic             link_en;
  logic [NPORT-1:0] status;
  logic [NPORT-1:0] mask;
  logic [DIVW-1:0]  clk_div [NCLK];
  logic             clk_ext [NCLK];
  logic [NCLK-1:0]  clk_tick;
  tio_port_cfg_t    cfg [NPORT];
  tio_port_stat_t   stat [NPORT];
  logic [DW-1:0]    drv [NPORT];
  logic [NPORT-1:0] port_stb;
  logic [NPORT-1:0] port_ev;
  logic [NPORT-1:0] port_tick;
  logic [NPORT-1:0] wr_data;
  logic [NPORT-1:0] rd_data;
  logic [2:0]       pidx;
  logic             psel;
  logic [DW-1:0]    next_rdata;
  logic [PINS-1:0]  next_pin_o;
  logic [PINS-1:0]  next_pin_oe;

  assign pidx = addr_i[7:5] - PORT_BASE_SEL;
  assign psel = (addr_i[7:6] != 2'b00) && (int'(pidx) < NPORT);

  // =====================================================================
  // input synchronisers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin0_d <= 1'b0;
      stb_s1 <= '0;
      stb_s2 <= '0;
    end else begin
      pin_s1 <= pin_i;
      pin_s2 <= pin_s1;
      pin0_d <= pin_s2[0];
      stb_s1 <= strobe_i;
      stb_s2 <= stb_s1;
    end
  end

  // =====================================================================
  // clock blocks
  assign clk_tick[0] = 1'b1;                                                     // RL13
  for (genvar k = 1; k < NCLK; k++) begin : g_clk
    logic [DIVW-1:0] div_cnt;
    assign clk_tick[k] = clk_ext[k] ? (pin_s2[0] && !pin0_d)                     // RL15
                                    : (div_cnt == clk_div[k]);                   // RL14
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        div_cnt <= CLK_DIV_RST;
      end else if (clk_ext[k] || (div_cnt == clk_div[k])) begin
        div_cnt <= CLK_DIV_RST;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // =====================================================================
  // ports
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    localparam int PW = PORT_W[p];
    logic [PW-1:0] drive;
    assign port_tick[p] = (int'(cfg[p].csel) < NCLK) ? clk_tick[cfg[p].csel] : 1'b0;
    assign wr_data[p]   = wr_i && psel && (int'(pidx) == p) && (addr_i[4:2] == PR_DATA);
    assign rd_data[p]   = rd_i && psel && (int'(pidx) == p) && (addr_i[4:2] == PR_DATA);
    assign drv[p]       = DW'(drive);
    tio_port #(.W(PW)) u_port (                                                  // RL1
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .cfg_i     (cfg[p]),
      .tick_i    (port_tick[p]),
      .pins_i    (pin_s2[PW-1:0]),
      .strobe_i  (stb_s2[p]),
      .wr_data_i (wr_data[p]),
      .wdata_i   (wdata_i),
      .rd_data_i (rd_data[p]),
      .stat_o    (stat[p]),
      .drive_o   (drive),
      .strobe_o  (port_stb[p]),
      .event_o   (port_ev[p])
    );
  end

  // =====================================================================
  // pin ownership
  always_comb begin
    next_pin_o  = '0;
    next_pin_oe = '0;
    for (int i = 0; i < PINS; i++) begin
      if (!(link_en && (i < LINK_PINS))) begin                                   // RL9
        for (int p = NPORT - 1; p >= 0; p--) begin
          if (cfg[p].en && (i < PORT_W[p])) begin                                // RL11
            next_pin_oe[i] = cfg[p].dir_out;                                     // RL10
            next_pin_o[i]  = drv[p][i];                                          // RL2
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o             <= '0;
      pin_oe_o          <= '0;
      outgoing_strobe_o <= '0;
      event_o           <= '0;
    end else begin
      pin_o             <= next_pin_o;
      pin_oe_o          <= next_pin_oe;
      outgoing_strobe_o <= port_stb;                                             // RL16
      event_o           <= port_ev;                                              // RL18
    end
  end

  // =====================================================================
  // register writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_en <= 1'b0;
      mask    <= '0;
      for (int k = 0; k < NCLK; k++) begin
        clk_div[k] <= CLK_DIV_RST;
        clk_ext[k] <= 1'b0;
      end
      for (int p = 0; p < NPORT; p++) begin
        cfg[p]      <= '0;
        cfg[p].csel <= CSEL_RST;                                                 // RL17
      end
    end else if (wr_i) begin                                                     // RL4
      if (addr_i == OFS_CTRL) begin
        link_en <= wdata_i[CTRL_LINK];
      end
      if (addr_i == OFS_MASK) begin
        mask <= wdata_i[NPORT-1:0];
      end
      for (int k = 1; k < NCLK; k++) begin
        if (addr_i == OFS_CLK_BASE + AW'(4 * k)) begin
          clk_div[k] <= wdata_i[DIVW-1:0];
          clk_ext[k] <= wdata_i[CLK_EXT];
        end
      end
      if (psel) begin
        case (addr_i[4:2])
          PR_CFG: begin
            cfg[pidx].en      <= wdata_i[CFG_EN];
            cfg[pidx].csel    <= wdata_i[CFG_CSEL +: 3];
            cfg[pidx].cond_en <= wdata_i[CFG_COND];
            cfg[pidx].time_en <= wdata_i[CFG_TIME];
            cfg[pidx].stbi_en <= wdata_i[CFG_STBI];
            cfg[pidx].stbo_en <= wdata_i[CFG_STBO];
            if (!cfg[pidx].en) begin
              cfg[pidx].dir_out <= wdata_i[CFG_DIR];                             // RL2
            end
          end
          PR_TIME: cfg[pidx].at_time <= wdata_i[CW-1:0];                         // RL7
          PR_COND: cfg[pidx].cond    <= wdata_i;                                 // RL3
          default: ;
        endcase
      end
    end
  end

  // =====================================================================
  // status, set wins over clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status <= '0;
      irq_o  <= 1'b0;
    end else begin
      if (wr_i && (addr_i == OFS_STATUS)) begin
        status <= (status & ~wdata_i[NPORT-1:0]) | port_ev;
      end else begin
        status <= status | port_ev;
      end
      irq_o <= |(status & mask);
    end
  end

  // =====================================================================
  // register reads
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (psel) begin
      case (addr_i[4:2])
        PR_CFG: begin
          next_rdata[CFG_EN]       = cfg[pidx].en;
          next_rdata[CFG_DIR]      = cfg[pidx].dir_out;
          next_rdata[CFG_CSEL +: 3] = cfg[pidx].csel;
          next_rdata[CFG_COND]     = cfg[pidx].cond_en;
          next_rdata[CFG_TIME]     = cfg[pidx].time_en;
          next_rdata[CFG_STBI]     = cfg[pidx].stbi_en;
          next_rdata[CFG_STBO]     = cfg[pidx].stbo_en;
          next_rdata[DW-2]         = stat[pidx].tx_full;
          next_rdata[DW-1]         = stat[pidx].rx_valid;
        end
        PR_DATA:   next_rdata = stat[pidx].rx_data;
        PR_TIME:   next_rdata = DW'(cfg[pidx].at_time);
        PR_COND:   next_rdata = cfg[pidx].cond;
        PR_COUNT:  next_rdata = DW'(stat[pidx].count);                           // RL7
        PR_TSTAMP: next_rdata = DW'(stat[pidx].tstamp);                          // RL8
        default:   next_rdata = 32'h0000_0000;
      endcase
    end else if (addr_i == OFS_CTRL) begin
      next_rdata[CTRL_LINK] = link_en;
    end else if (addr_i == OFS_STATUS) begin
      next_rdata[NPORT-1:0] = status;
    end else if (addr_i == OFS_MASK) begin
      next_rdata[NPORT-1:0] = mask;
    end else begin
      for (int k = 1; k < NCLK; k++) begin
        if (addr_i == OFS_CLK_BASE + AW'(4 * k)) begin
          next_rdata[DIVW-1:0] = clk_div[k];
          next_rdata[CLK_EXT]  = clk_ext[k];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule
